// file: hw/ecs_status_terminal.v
// Customer-side status responder and virtual terminal session handler.
`timescale 1ns/100ps
`include "ecs_consts.vh"
module ecs_status_terminal #(
	parameter PAGE_W    = 6,
	parameter PAGES_W   = 2,
	parameter MS_CYCLES = `ECS_MS_NS / `ECS_CLK_NS
) (
	// Clock and reset
	input  wire        ref_clk,
	input  wire        nrst,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	// Line monitor events and conditions
	input  wire        esEvent,
	input  wire        sesEvent,
	input  wire        loswSecEvent,
	input  wire        uasEvent,
	input  wire        crcAnomaly,
	input  wire        hwFault,
	input  wire        spanOpen,
	input  wire        spanShort,
	input  wire        snrAlarm,
	input  wire        attenAlarm,
	input  wire        loswFailure,
	// Status poll from the message layer
	input  wire        statusReq,
	input  wire        statusToCo,
	input  wire [3:0]  statusDest,
	// Received single-octet session messages
	input  wire        rxValid,
	input  wire [7:0]  rxData,
	input  wire [3:0]  rxSrc,
	// Transmit octet stream
	input  wire        txReady,
	output reg         txValid,
	output reg  [7:0]  txData,
	output reg         txLast,
	output reg  [3:0]  txDest,
	// Session state
	output reg         sessionActive
);
	localparam TX_IDLE = 2'h0;
	localparam TX_STAT = 2'h1;
	localparam TX_CONN = 2'h2;
	localparam TX_SCR  = 2'h3;
	localparam AW = PAGE_W + PAGES_W;

	reg  [31:0]        ctrl;
	reg  [17:0]        meas;
	reg  [15:0]        timeoutMs;
	reg  [PAGE_W:0]    pageLen;
	reg  [PAGES_W-1:0] curPage;
	reg  [7:0]         screen [0:(1<<AW)-1];
	reg  [7:0]         cnt8 [0:3];
	reg  [15:0]        crcCnt;
	reg                ovfCo, ovfCu, rstCo, rstCu;
	reg  [3:0]         owner;
	reg  [31:0]        msDiv;
	reg  [15:0]        idleMs;
	reg                statPend, statPendCo;
	reg  [3:0]         statPendDest;
	reg                connPend, connPendOk, connPendNew;
	reg  [3:0]         connPendDest;
	reg  [1:0]         txState;
	reg  [4:0]         idx;
	reg                sendCo, connOk, connNew;
	reg  [7:0]         snapOct11;
	reg  [15:0]        snapCrc;
	reg  [PAGE_W:0]    scrPtr;
	reg                aWrite, aRead;
	reg  [7:0]         aAddr;
	reg  [7:0]         octet;
	reg                octLast;

	// Event pulses in counter order: errored, severely errored, sync-loss, unavailable.
	wire [3:0] evt = {uasEvent, loswSecEvent, sesEvent, esEvent};
	wire [3:0] wrap;
	wire       counterClr = aWrite && aAddr == `ECS_REG_CTRL && hwdata[`ECS_CTRL_CLR];
	wire       anyWrap = (|wrap) || (crcAnomaly && crcCnt == 16'hffff);
	wire       txFree = !txValid || txReady;
	wire       devFault = hwFault || ctrl[`ECS_CTRL_FAULT];
	wire       dcFault = spanOpen || spanShort;
	wire       startStat = txFree && txState == TX_IDLE && !connPend && statPend;
	wire       startConn = txFree && txState == TX_IDLE && connPend;
	wire       msTick = msDiv == MS_CYCLES - 1;
	wire       isConnect = rxValid && rxData == `ECS_ID_CONNECT;
	wire       timedOut = sessionActive && timeoutMs != 16'h0000 && idleMs >= timeoutMs;
	// A page longer than one message is cut into full messages and a shorter tail.
	wire       pageEnd = scrPtr + {{PAGE_W{1'b0}}, 1'b1} >= pageLen;

	// Each modulo counter rolls over silently; the wrap only shows in octet 11.
	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1) begin : gCnt
			assign wrap[i] = evt[i] && cnt8[i] == 8'hff;
			always @(posedge ref_clk or negedge nrst) begin
				if (!nrst)
					cnt8[i] <= 8'h00;
				else if (counterClr)
					cnt8[i] <= 8'h00;
				else if (evt[i])
					cnt8[i] <= cnt8[i] + 8'h01;
			end
		end
	endgenerate

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			crcCnt <= 16'h0000;
		else if (counterClr)
			crcCnt <= 16'h0000;
		else if (crcAnomaly)
			crcCnt <= crcCnt + 16'h0001;
	end

	// Power-up counts as a counter reset, so both reset flags start set.
	// An event in the cycle of a snapshot wins over that snapshot's clear.
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ovfCo <= 1'b0;
			ovfCu <= 1'b0;
			rstCo <= 1'b1;
			rstCu <= 1'b1;
		end else begin
			if (anyWrap) begin
				ovfCo <= 1'b1;
				ovfCu <= 1'b1;
			end else if (startStat && statPendCo)
				ovfCo <= 1'b0;
			else if (startStat)
				ovfCu <= 1'b0;
			if (counterClr) begin
				rstCo <= 1'b1;
				rstCu <= 1'b1;
			end else if (startStat && statPendCo)
				rstCo <= 1'b0;
			else if (startStat)
				rstCu <= 1'b0;
		end
	end

	// Register bus: zero wait states, reads are prepared in the address phase.
	// The transfer size is not decoded, so a narrow write still updates the
	// whole word; software must always write complete registers.
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			aWrite    <= 1'b0;
			aRead     <= 1'b0;
			aAddr     <= 8'h00;
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			aWrite    <= hsel && hready && htrans[1] && hwrite;
			aRead     <= hsel && hready && htrans[1] && !hwrite;
			aAddr     <= haddr[7:0];
			if (hsel && hready && htrans[1] && !hwrite) begin
				case (haddr[7:0])
				`ECS_REG_CTRL:    hrdata <= ctrl;
				`ECS_REG_MEAS:    hrdata <= {14'h0000, meas};
				`ECS_REG_TIMEOUT: hrdata <= {16'h0000, timeoutMs};
				`ECS_REG_SCRLEN:  hrdata <= {{(31-PAGE_W){1'b0}}, pageLen};
				`ECS_REG_STATE:   hrdata <= {16'h0000, snapOct11, owner,
					{(3-PAGES_W){1'b0}}, curPage, sessionActive};
				`ECS_REG_CNT8:    hrdata <= {cnt8[3], cnt8[2], cnt8[1], cnt8[0]};
				`ECS_REG_CNTCRC:  hrdata <= {16'h0000, crcCnt};
				default:          hrdata <= 32'h00000000;
				endcase
			end
		end
	end

	// Screen store; written only by software, one byte per bus write.
	always @(posedge ref_clk) begin
		if (aWrite && aAddr == `ECS_REG_SCRDATA)
			screen[hwdata[AW+7:8]] <= hwdata[7:0];
	end

	// Software registers and the session owner share this process because a
	// new connection overrides the page that software last selected.
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl          <= {14'h0000, `ECS_LOOP_DEFAULT, 16'h0001};
			meas          <= 18'h00000;
			timeoutMs     <= 16'h0000;
			pageLen       <= {{PAGE_W{1'b0}}, 1'b1};
			curPage       <= {PAGES_W{1'b0}};
			sessionActive <= 1'b0;
			owner         <= 4'h0;
			connPend      <= 1'b0;
			connPendOk    <= 1'b0;
			connPendNew   <= 1'b0;
			connPendDest  <= 4'h0;
		end else begin
			if (aWrite) begin
				case (aAddr)
				`ECS_REG_CTRL:    ctrl <= hwdata & ~(32'h1 << `ECS_CTRL_CLR);
				`ECS_REG_MEAS:    meas <= hwdata[17:0];
				`ECS_REG_TIMEOUT: timeoutMs <= hwdata[15:0];
				`ECS_REG_SCRLEN: begin
					pageLen <= (hwdata[PAGE_W:0] == {(PAGE_W+1){1'b0}}) ?
						{{PAGE_W{1'b0}}, 1'b1} : hwdata[PAGE_W:0];
					curPage <= hwdata[PAGES_W+15:16];
				end
				default: ;
				endcase
			end
			if (startConn)
				connPend <= 1'b0;
			// A connect that arrives while an earlier answer still waits is dropped
			// rather than queued; the requester repeats it if no answer comes.
			if (isConnect && !connPend) begin
				if (!ctrl[`ECS_CTRL_TERM]) begin
					connPend     <= ctrl[`ECS_CTRL_NAK];
					connPendOk   <= 1'b0;
					connPendNew  <= 1'b0;
					connPendDest <= rxSrc;
				end else if (sessionActive && owner != rxSrc) begin
					connPend     <= 1'b1;
					connPendOk   <= 1'b0;
					connPendNew  <= 1'b0;
					connPendDest <= rxSrc;
				end else begin
					connPend      <= 1'b1;
					connPendOk    <= 1'b1;
					connPendNew   <= !sessionActive;
					connPendDest  <= rxSrc;
					sessionActive <= 1'b1;
					owner         <= rxSrc;
					if (!sessionActive)
						curPage <= {PAGES_W{1'b0}};
				end
			end else if (rxValid && rxData == `ECS_ID_DISCONNECT && owner == rxSrc)
				sessionActive <= 1'b0;
			else if (timedOut)
				sessionActive <= 1'b0;
		end
	end

	// Inactivity timer in milliseconds; any message from the owner restarts it.
	// The divider runs free, so the first counted millisecond may be short and
	// the timeout is exact only to within one millisecond.
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			msDiv  <= 32'h00000000;
			idleMs <= 16'h0000;
		end else begin
			msDiv <= msTick ? 32'h00000000 : msDiv + 32'h00000001;
			if (!sessionActive || (rxValid && rxSrc == owner))
				idleMs <= 16'h0000;
			else if (msTick && idleMs != 16'hffff)
				idleMs <= idleMs + 16'h0001;
		end
	end

	// A poll that arrives while an earlier one waits replaces it.
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			statPend     <= 1'b0;
			statPendCo   <= 1'b0;
			statPendDest <= 4'h0;
		end else if (statusReq) begin
			statPend     <= 1'b1;
			statPendCo   <= statusToCo;
			statPendDest <= statusDest;
		end else if (startStat)
			statPend <= 1'b0;
	end

	always @* begin
		octet   = 8'h00;
		octLast = 1'b0;
		case (txState)
		TX_STAT: begin
			octLast = idx == `ECS_STATUS_LAST;
			case (idx)
			5'h00: octet = `ECS_ID_STATUS;
			5'h01: octet = {1'b0, ctrl[`ECS_CTRL_PBOSEL], devFault, dcFault,
				snrAlarm, attenAlarm, loswFailure, 1'b0};
			5'h02: octet = meas[16] ? meas[7:0] : `ECS_SNR_NA;
			5'h03: octet = meas[17] ? meas[15:8] : `ECS_ATTEN_NA;
			5'h04: octet = cnt8[0];
			5'h05: octet = cnt8[1];
			5'h06: octet = snapCrc[15:8];
			5'h07: octet = snapCrc[7:0];
			5'h08: octet = cnt8[2];
			5'h09: octet = cnt8[3];
			5'h0a: octet = snapOct11;
			5'h0b: octet = {ctrl[`ECS_CTRL_PBOEXT], 5'h00, ctrl[17:16]};
			default: octet = 8'h00;
			endcase
		end
		TX_CONN: begin
			octLast = idx == 5'h01;
			octet   = (idx == 5'h00) ? `ECS_ID_CONN_RESP :
				(connOk ? `ECS_CONN_OK : `ECS_CONN_NAK);
		end
		TX_SCR: begin
			// The cut follows the octet index, never the remainder that shrinks as it goes.
			octLast = idx == `ECS_SCREEN_MAX || (idx != 5'h00 && pageEnd);
			octet   = (idx == 5'h00) ? `ECS_ID_SCREEN :
				screen[{curPage, scrPtr[PAGE_W-1:0]}];
		end
		default: ;
		endcase
	end

	// Octet stream out; a pending connect answer goes ahead of a status poll.
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			txState   <= TX_IDLE;
			idx       <= 5'h00;
			txValid   <= 1'b0;
			txData    <= 8'h00;
			txLast    <= 1'b0;
			txDest    <= 4'h0;
			sendCo    <= 1'b0;
			connOk    <= 1'b0;
			connNew   <= 1'b0;
			snapOct11 <= 8'h00;
			snapCrc   <= 16'h0000;
			scrPtr    <= {(PAGE_W+1){1'b0}};
		end else if (txFree) begin
			if (txState == TX_IDLE) begin
				txValid <= 1'b0;
				txLast  <= 1'b0;
				idx     <= 5'h00;
				if (connPend) begin
					txState <= TX_CONN;
					txDest  <= connPendDest;
					connOk  <= connPendOk;
					connNew <= connPendNew;
				end else if (statPend) begin
					txState   <= TX_STAT;
					txDest    <= statPendDest;
					sendCo    <= statPendCo;
					// Octet 11 and the anomaly count are frozen together so that the
					// clear of the indications and the report describe one instant.
					snapOct11 <= {ovfCo, rstCo, ovfCu, rstCu, ctrl[11:8]};
					snapCrc   <= crcCnt;
				end
			end else begin
				txValid <= 1'b1;
				txData  <= octet;
				txLast  <= octLast;
				idx     <= octLast ? 5'h00 : idx + 5'h01;
				if (txState == TX_SCR && idx != 5'h00)
					scrPtr <= scrPtr + {{PAGE_W{1'b0}}, 1'b1};
				if (octLast) begin
					case (txState)
					TX_CONN: begin
						scrPtr  <= {(PAGE_W+1){1'b0}};
						txState <= connOk ? TX_SCR : TX_IDLE;
					end
					TX_SCR:  txState <= pageEnd ? TX_IDLE : TX_SCR;
					default: txState <= TX_IDLE;
					endcase
				end
			end
		end
	end
endmodule

// file: include/ecs_consts.vh
// Constants for the customer-side status and terminal session handler.
`ifndef ECS_CONSTS_VH
`define ECS_CONSTS_VH
`define ECS_ID_STATUS      8'h8d
`define ECS_ID_CONNECT     8'h06
`define ECS_ID_DISCONNECT  8'h07
`define ECS_ID_KEYBOARD    8'h08
`define ECS_ID_CONN_RESP   8'h86
`define ECS_ID_SCREEN      8'h88
`define ECS_CONN_OK        8'h01
`define ECS_CONN_NAK       8'h00
`define ECS_SNR_NA         8'h7f
`define ECS_ATTEN_NA       8'h80
`define ECS_STATUS_LAST    5'h0b
`define ECS_SCREEN_MAX     5'h18
`define ECS_CLK_NS         10
`define ECS_MS_NS          1000000
`define ECS_REG_CTRL       8'h00
`define ECS_REG_MEAS       8'h04
`define ECS_REG_TIMEOUT    8'h08
`define ECS_REG_SCRLEN     8'h0c
`define ECS_REG_SCRDATA    8'h10
`define ECS_REG_STATE      8'h14
`define ECS_REG_CNT8       8'h18
`define ECS_REG_CNTCRC     8'h1c
`define ECS_CTRL_TERM      0
`define ECS_CTRL_NAK       1
`define ECS_CTRL_CLR       2
`define ECS_CTRL_PBOSEL    3
`define ECS_CTRL_FAULT     4
`define ECS_CTRL_PBOEXT    12
`define ECS_LOOP_DEFAULT   2'h1
`endif

// file: verif/ecs_status_terminal_bench.sv
// Self-checking bench for the status responder and terminal sessions.
`timescale 1ns/100ps
module ecs_status_terminal_bench;
	logic ref_clk = 0, nrst = 0, hsel = 0, hwrite = 0, statusReq = 0, statusToCo = 0;
	logic rxValid = 0, sel, swf, ext, hreadyout, hresp, txReady, txValid, txLast, act;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic [1:0] htrans = 0, lp;
	logic [4:0] ev = 0;
	logic [5:0] al = 0;
	logic [7:0] rxData = 0, txData, snr, att, scr[3];
	logic [3:0] rxSrc = 0, txDest, statusDest = 0, base, fl;
	logic [7:0] m[$];
	int errors = 0, comparisons = 0, cnt[5];
	always #5 ref_clk = ~ref_clk;
	ecs_status_terminal #(.MS_CYCLES(10)) ecs_status_terminal_inst (.ref_clk(ref_clk),
		.nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .esEvent(ev[0]), .sesEvent(ev[1]),
		.loswSecEvent(ev[2]), .uasEvent(ev[3]), .crcAnomaly(ev[4]), .hwFault(al[5]),
		.spanOpen(al[4]), .spanShort(al[3]), .snrAlarm(al[2]), .attenAlarm(al[1]),
		.loswFailure(al[0]), .statusReq(statusReq), .statusToCo(statusToCo),
		.statusDest(statusDest), .rxValid(rxValid), .rxData(rxData), .rxSrc(rxSrc),
		.txReady(txReady), .txValid(txValid), .txData(txData), .txLast(txLast),
		.txDest(txDest), .sessionActive(act));
	ecs_stream_sink sink_inst (.ref_clk(ref_clk), .nrst(nrst), .txValid(txValid),
		.txData(txData), .txLast(txLast), .txReady(txReady));
	task automatic chk(input string n, input logic [31:0] e, s);
		comparisons++;
		if (s !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a, d);
		hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'h2;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic get();
		logic [8:0] o;
		m = {};
		do begin
			while (sink_inst.octs.size() == 0) @(posedge ref_clk);
			o = sink_inst.octs.pop_front();
			m.push_back(o[7:0]);
		end while (!o[8]);
	endtask
	task automatic ctrl(input logic clr, input logic [1:0] mode = 2'h1);
		bus(1, 0, {14'h0, lp, 3'h0, ext, base, 3'h0, swf, sel, clr, mode});
	endtask
	task automatic rx(input logic [7:0] d, input logic [3:0] s);
		rxValid <= 1'b1; rxData <= d; rxSrc <= s;
		@(posedge ref_clk) rxValid <= 1'b0;
		get();
	endtask
	task automatic poll(input logic co);
		logic [7:0] e[12];
		al <= 6'($urandom); statusDest <= 4'($urandom); statusToCo <= co; statusReq <= 1'b1;
		@(posedge ref_clk) statusReq <= 1'b0;
		get();
		e = '{8'h8d, {1'b0, sel, al[5] | swf, al[4] | al[3], al[2:0], 1'b0}, snr, att,
			cnt[0][7:0], cnt[1][7:0], cnt[4][15:8], cnt[4][7:0], cnt[2][7:0], cnt[3][7:0],
			{fl, base}, {ext, 5'h00, lp}};
		chk("status size", 12, m.size());
		chk("dest", statusDest, txDest);
		for (int i = 0; i < 12; i++)
			chk($sformatf("octet %0d", i + 1), e[i], m[i]);
		fl &= co ? 4'h3 : 4'hc;
	endtask
	task automatic events(input int n, input logic [4:0] only);
		repeat (n) begin
			ev <= only ? only : 5'($urandom);
			@(posedge ref_clk);
			for (int k = 0; k < 5; k++)
				if (ev[k] && ++cnt[k] % (k == 4 ? 65536 : 256) == 0)
					fl |= 4'ha;
		end
		ev <= 5'h00;
	endtask
	task automatic end_of_test();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#300000;
		errors++;
		end_of_test();
	end
	initial begin
		void'($urandom(32'h9d02d62b));
		{sel, swf, ext, base} = 7'($urandom);
		lp = 2'($urandom % 2 + 1);
		cnt = '{default: 0};
		fl = 4'h5;
		repeat (12) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		ctrl(0);
		bus(1, 4, 0);
		{snr, att} = 16'h7f80;
		poll(1);
		events(40, 0);
		poll(0);
		{snr, att} = 16'($urandom);
		bus(1, 4, {14'h0, 2'h3, att, snr});
		sink_inst.slow = 1'b1;
		events(300, 5'h01);
		poll(1);
		poll(0);
		bus(0, 32'h18, 0);
		chk("cnt8", {cnt[3][7:0], cnt[2][7:0], cnt[1][7:0], cnt[0][7:0]}, rd);
		bus(0, 32'h1c, 0);
		chk("crc", cnt[4][15:0], rd);
		bus(0, 32'h20, 0);
		chk("unmapped", 0, rd);
		ctrl(1);
		cnt = '{default: 0};
		fl |= 4'h5;
		poll(0);
		ctrl(0, 2'h2);
		rx(8'h06, 4'h3);
		chk("nak", 16'h8600, {m[0], m[1]});
		ctrl(0, 2'h0);
		rxValid <= 1'b1;
		rxData <= 8'h06;
		@(posedge ref_clk) rxValid <= 1'b0;
		repeat (20) @(posedge ref_clk);
		chk("ignored", 0, sink_inst.octs.size() + act);
		ctrl(0);
		bus(1, 32'h0c, {14'h0, 2'h1, 16'h3});
		for (int k = 0; k < 3; k++) begin
			scr[k] = 8'($urandom);
			bus(1, 32'h10, {16'h0, 2'h0, 6'(k), scr[k]});
		end
		bus(1, 8, 8);
		for (int t = 0; t < 3; t++) begin
			if (t == 1)
				bus(1, 32'h0c, {14'h0, 2'h1, 16'h3});
			rx(8'h06, 4'h3);
			chk("resp", 16'h8601, {m[0], m[1]});
			get();
			chk("screen len", 4, m.size());
			for (int k = 0; k < 4; k++)
				chk("screen", k ? scr[k - 1] : 8'h88, m[k]);
			chk("active", 1, act);
			if (t != 1) begin
				rx(8'h06, 4'h5);
				chk("busy", 16'h8600, {m[0], m[1]});
				rxValid <= (t == 0);
				rxData <= 8'h07;
				rxSrc <= 4'h3;
				@(posedge ref_clk) rxValid <= 1'b0;
				repeat (t ? 300 : 2) if (act) @(posedge ref_clk);
				chk("ended", 0, act);
			end
		end
		end_of_test();
	end
endmodule
bind ecs_status_terminal ecs_status_terminal_props ecs_status_terminal_props_inst (
	.ref_clk(ref_clk), .nrst(nrst), .hreadyout(hreadyout), .hresp(hresp),
	.statusReq(statusReq), .rxValid(rxValid), .txReady(txReady), .txValid(txValid),
	.txData(txData), .txLast(txLast), .sessionActive(sessionActive));

// file: verif/ecs_status_terminal_props.sv
// Concurrent checks on the status responder and session handler ports.
`timescale 1ns/100ps
module ecs_status_terminal_props (
	// Clock and reset
	input wire       ref_clk,
	input wire       nrst,
	// Watched ports
	input wire       hreadyout,
	input wire       hresp,
	input wire       statusReq,
	input wire       rxValid,
	input wire       txReady,
	input wire       txValid,
	input wire [7:0] txData,
	input wire       txLast,
	input wire       sessionActive
);
	// Octet index and identifier of the message now on the stream.
	reg [4:0] cnt;
	reg [7:0] id;
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cnt <= 5'h00;
			id <= 8'h00;
		end else if (txValid && txReady) begin
			cnt <= txLast ? 5'h00 : cnt + 5'h01;
			if (cnt == 5'h00)
				id <= txData;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	property p_first;
		statusReq && !txValid && !$past(txValid) && !rxValid && !$past(rxValid)
			&& !sessionActive |-> ##3 (txValid && txData == 8'h8d);
	endproperty
	a_first: assert property (p_first) else $error("status id late or wrong");
	property p_stlen;
		txValid && txLast && id == 8'h8d && cnt != 5'h00 |-> cnt == 5'h0b;
	endproperty
	a_stlen: assert property (p_stlen) else $error("status length wrong");
	property p_bit0;
		txValid && cnt == 5'h01 && id == 8'h8d |-> !txData[0];
	endproperty
	a_bit0: assert property (p_bit0) else $error("reserved flag set");
	property p_resp;
		txValid && cnt == 5'h01 && id == 8'h86 |-> txLast && txData[7:1] == 7'h00;
	endproperty
	a_resp: assert property (p_resp) else $error("connect response malformed");
	property p_screen;
		txValid && txLast && id == 8'h88 && cnt != 5'h00 |-> cnt <= 5'h18;
	endproperty
	a_screen: assert property (p_screen) else $error("screen too long");
	property p_scrid;
		txValid && txReady && txLast && cnt == 5'h01 && id == 8'h86 && txData == 8'h01
			|-> ##[1:20] (txValid && cnt == 5'h00 && txData == 8'h88);
	endproperty
	a_scrid: assert property (p_scrid) else $error("no screen after connect");
	property p_hold;
		txValid && !txReady |=> txValid && $stable(txData) && $stable(txLast);
	endproperty
	a_hold: assert property (p_hold) else $error("stream octet dropped");
	property p_ready;
		$past(nrst) |-> hreadyout && !hresp;
	endproperty
	a_ready: assert property (p_ready) else $error("bus not ready or error");
endmodule

// file: verif/ecs_stream_sink.sv
// Message layer model that takes the handler's transmit octets.
`timescale 1ns/100ps
module ecs_stream_sink (
	// Clock and reset
	input wire       ref_clk,
	input wire       nrst,
	// Octet stream
	input wire       txValid,
	input wire [7:0] txData,
	input wire       txLast,
	output reg       txReady
);
	// Each entry is {last, octet}; the bench cuts messages at the last flag.
	logic [8:0] octs[$];
	logic       slow = 1'b0;
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			txReady <= 1'b0;
		else begin
			if (txValid && txReady)
				octs.push_back({txLast, txData});
			txReady <= slow ? ($urandom % 3 != 0) : 1'b1;
		end
	end
endmodule
